//--- core_model.sv
// behavioural processor core that accepts vectors and owns the mask bit
`timescale 1ns/1ps

module core_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // controller side
    input wire intc_pkg::grant_t grant,
    output logic intAck,
    output logic ccrMask,
    // bench control
    input wire logic [3:0] ackDelay,
    input wire logic setI,
    input wire logic clrI,
    output logic [5:0] lastNumber,
    output logic [7:0] ackCount
);
    import intc_pkg::*;
    logic [3:0] waitCnt;

    // accept after a chosen delay, one cycle pulse
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            intAck <= 1'b0;
            waitCnt <= 4'h0;
            lastNumber <= 6'h00;
            ackCount <= 8'h00;
        end else if (intAck) begin
            intAck <= 1'b0;
        end else if (grant.valid && waitCnt >= ackDelay) begin
            intAck <= 1'b1;
            waitCnt <= 4'h0;
            lastNumber <= grant.number;
            ackCount <= ackCount + 8'h01;
        end else if (grant.valid) begin
            waitCnt <= waitCnt + 4'h1;
        end
    end

    // mask bit set by reset and by every accepted vector
    always_ff @(posedge sys_clk) begin
        if (rst || setI || (grant.valid && intAck)) begin
            ccrMask <= 1'b1;
        end else if (clrI) begin
            ccrMask <= 1'b0;
        end
    end
endmodule : core_model

//--- intc_pkg.sv
// shared constants and types of the prioritized vectored interrupt controller
package intc_pkg;

    // ----------------------------------------------------------------
    // register indexes and byte addresses
    // ----------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_SYSCTL = 16'hffc4;
    localparam logic [15:0] IDX_SENSE = 16'hffc6;
    localparam logic [15:0] IDX_ENABLE = 16'hffc7;
    localparam logic [15:0] IDX_KEYLO = 16'hfff1;
    localparam logic [15:0] IDX_KEYHI = 16'hfff3;
    localparam logic [15:0] IDX_STATUS = 16'hffd0;
    localparam logic [15:0] IDX_MASK = 16'hffd1;
    localparam logic [15:0] IDX_ROUTE = 16'hffd2;
    localparam logic [ADDR_W-1:0] ADDR_SYSCTL = {IDX_SYSCTL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_SENSE = {IDX_SENSE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = {IDX_ENABLE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_KEYLO = {IDX_KEYLO, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_KEYHI = {IDX_KEYHI, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ROUTE = {IDX_ROUTE, 2'b00};

    // ----------------------------------------------------------------
    // reset values and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] SYSCTL_RST = 8'h09;
    localparam logic [7:0] SYSCTL_RO_MASK = 8'h08;
    localparam int NMI_EDGE_BIT = 2;
    localparam logic [7:0] SENSE_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] KEYLO_RST = 8'hbf;
    localparam logic [7:0] KEYHI_RST = 8'hff;
    localparam int ST_W = 3;
    localparam int ST_NMI = 0;
    localparam int ST_GRANT = 1;
    localparam int ST_KEY = 2;
    localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
    localparam logic [ST_W-1:0] MASK_RST = 3'h0;
    localparam logic ROUTE_RST = 1'b0;

    // ----------------------------------------------------------------
    // sources and vectors
    // ----------------------------------------------------------------
    localparam int NUM_EXT = 8;
    localparam int NUM_KEY = 16;
    localparam int NUM_INT = 26;
    localparam int NUM_SRC = 35;
    localparam int KEY_LINE = 6;
    localparam int WDT_IDX = 24;
    localparam logic [5:0] VEC_NMI = 6'h03;
    localparam logic [5:0] VEC_EXT0 = 6'h04;
    localparam logic [5:0] VEC_INT0 = 6'h0c;
    localparam logic [5:0] VEC_WDT = 6'h24;
    localparam logic [5:0] VEC_LAST = 6'h25;
    localparam logic [7:0] RESET_VEC_ADDR = 8'h00;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [5:0] number;
        logic [7:0] addr;
    } grant_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef enum logic [0:0] {
        ARB_IDLE = 1'b0,
        ARB_OFFER = 1'b1
    } arb_state_t;

endpackage : intc_pkg

//--- intc_props.sv
// port assertions and covers for the interrupt controller
`timescale 1ns/1ps

module intc_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // processor core
    input wire logic ccrMask,
    input wire logic intAck,
    input wire intc_pkg::grant_t grant
);
    import intc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    a_ready_one_wait: assert property (psel && !penable |=> pready && psel && penable)
        else $error("late pready");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_error_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");

    // ------------------------------------------------------------
    // vector hand-over
    // ------------------------------------------------------------
    a_vector_address: assert property (grant.valid |-> grant.addr == {1'b0, grant.number, 1'b0})
        else $error("bad vector address");
    a_vector_range: assert property (grant.valid |-> grant.number inside {[VEC_NMI:VEC_LAST]})
        else $error("vector out of range");
    a_grant_hold: assert property (grant.valid && !intAck |=> grant.valid && $stable(grant))
        else $error("grant not held");
    a_ack_release: assert property (grant.valid && intAck |=> !grant.valid)
        else $error("grant not released");
    a_mask_blocks: assert property ($rose(grant.valid) && $past(ccrMask) |-> grant.number == VEC_NMI)
        else $error("masked request granted");

    c_nmi_grant: cover property ($rose(grant.valid) && grant.number == VEC_NMI);
    c_last_grant: cover property ($rose(grant.valid) && grant.number == VEC_LAST);
    c_bus_error: cover property (pslverr);
endmodule : intc_checker

bind prioritized_vectored_interrupt_ctrl intc_checker intc_checker_i (
    .sys_clk, .rst, .psel, .penable, .pready, .pslverr, .ccrMask, .intAck, .grant
);

//--- prioritized_vectored_interrupt_ctrl.sv
// prioritized vectored interrupt controller with APB register access
// Summary of operation
// - several pending requests: grant highest fixed priority, others stay pending
// - nonmaskable request ranks first and ignores the processor mask bit
// - processor mask bit at 1 blocks every request but the nonmaskable one
// - each external line selects falling-edge or low-level requesting
// - nonmaskable input is edge-detected; edge chosen by system control bit 2
// - edge select 0 means falling edge, 1 means rising edge
// - each source gets its own distinct vector number
// - line 6 combines its pin with 16 individually maskable key inputs
// - vectors run 3 to 37, priority falls with number, address twice number
// - lowest two vector table bytes hold the reset vector
// - table entries between reset and nonmaskable vectors stay unused
// - nine external sources on 25 pins plus 26 internal sources
// - watchdog overflow routes to nonmaskable or its own maskable vector
// - sense bit 0 selects low level, 1 selects falling edge
// - enable bit resets to 0; 0 blocks new requests, 1 allows them
// - key mask 0 enables, 1 masks; reset all 1 except key 6
// - latched edge request stays; cleared by its own acknowledge or with mask 1, sense 0, enable 0
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

module prioritized_vectored_interrupt_ctrl (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [intc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request pins, active low
    input wire logic nmiPin_n,
    input wire logic [7:0] irqPin_n,
    input wire logic [15:0] keyPin_n,
    // on-chip peripheral requests
    input wire logic [25:0] internalReq,
    input wire logic wdtOvf,
    // processor core
    input wire logic ccrMask,
    input wire logic intAck,
    output intc_pkg::grant_t grant,
    // event interrupt
    output logic irqOut
);
    import intc_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // lowest set index wins, so priority falls as the vector rises
    function automatic logic [5:0] firstSet(input logic [NUM_SRC-1:0] r);
        logic [5:0] idx;
        idx = 6'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (r[i]) begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction : firstSet

    function automatic logic [7:0] vecAddr(input logic [5:0] num);
        return {1'b0, num, 1'b0};
    endfunction : vecAddr

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    apb_req_t bus;
    apb_rsp_t rsp;
    logic [7:0] sysctl_reg;
    logic [7:0] sense_reg;
    logic [7:0] enable_reg;
    logic [7:0] keyLo_reg;
    logic [7:0] keyHi_reg;
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] mask_reg;
    logic route_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irqOut_reg;
    grant_t grant_reg;
    grant_t grant_next;
    arb_state_t state_reg;
    arb_state_t state_next;
    logic [24:0] syncA_reg;
    logic [24:0] syncB_reg;
    logic [24:0] syncC_reg;
    logic [24:0] filt_reg;
    logic nmiPrev_reg;
    logic [NUM_EXT-1:0] lineLowPrev_reg;
    logic [NUM_EXT-1:0] edgePend_reg;
    logic nmiPend_reg;
    logic wdtPend_reg;

    // ----------------------------------------------------------------
    // decoded signals
    // ----------------------------------------------------------------
    logic [31:0] rdData;
    logic rdHit;
    logic wrEn;
    logic [24:0] agree;
    logic nmiLvl;
    logic [NUM_EXT-1:0] irqLvl;
    logic [NUM_KEY-1:0] keyLvl;
    logic [NUM_KEY-1:0] keyHit;
    logic [NUM_EXT-1:0] lineLow;
    logic [NUM_EXT-1:0] lineFall;
    logic nmiEdge;
    logic nmiSet;
    logic wdtSet;
    logic [NUM_EXT-1:0] extReq;
    logic [NUM_EXT-1:0] edgeClr;
    logic [NUM_INT-1:0] intReq;
    logic [NUM_SRC-1:0] reqs;
    logic [5:0] winIdx;
    logic [5:0] winNum;
    logic ackHit;
    logic [ST_W-1:0] events;

    assign bus = '{psel, penable, pwrite, paddr, pwdata};
    assign rsp = '{prdata_reg, pready_reg, pslverr_reg};
    assign prdata = rsp.prdata;
    assign pready = rsp.pready;
    assign pslverr = rsp.pslverr;
    assign grant = grant_reg;
    assign irqOut = irqOut_reg;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    // no wait states: data and error are loaded during setup
    assign wrEn = bus.psel & bus.penable & pready_reg & bus.pwrite;

    always_comb begin
        rdData = 32'h0000_0000;
        rdHit = 1'b1;
        unique case (bus.paddr)
            ADDR_SYSCTL: rdData[7:0] = sysctl_reg;
            ADDR_SENSE: rdData[7:0] = sense_reg;
            ADDR_ENABLE: rdData[7:0] = enable_reg;
            ADDR_KEYLO: rdData[7:0] = keyLo_reg;
            ADDR_KEYHI: rdData[7:0] = keyHi_reg;
            ADDR_STATUS: rdData[ST_W-1:0] = status_reg;
            ADDR_MASK: rdData[ST_W-1:0] = mask_reg;
            ADDR_ROUTE: rdData[0] = route_reg;
            default: rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= bus.psel & ~bus.penable;
            if (bus.psel & ~bus.penable) begin
                prdata_reg <= bus.pwrite ? 32'h0000_0000 : rdData;
                pslverr_reg <= ~rdHit;
            end else if (pready_reg) begin
                prdata_reg <= 32'h0000_0000;
                pslverr_reg <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sysctl_reg <= SYSCTL_RST;
            sense_reg <= SENSE_RST;
            enable_reg <= ENABLE_RST;
            keyLo_reg <= KEYLO_RST;
            keyHi_reg <= KEYHI_RST;
            mask_reg <= MASK_RST;
            route_reg <= ROUTE_RST;
        end else if (wrEn) begin
            unique case (bus.paddr)
                ADDR_SYSCTL: begin
                    sysctl_reg <= (bus.pwdata[7:0] & ~SYSCTL_RO_MASK)
                        | (sysctl_reg & SYSCTL_RO_MASK);
                end
                ADDR_SENSE: sense_reg <= bus.pwdata[7:0];
                ADDR_ENABLE: enable_reg <= bus.pwdata[7:0];
                ADDR_KEYLO: keyLo_reg <= bus.pwdata[7:0];
                ADDR_KEYHI: keyHi_reg <= bus.pwdata[7:0];
                ADDR_MASK: mask_reg <= bus.pwdata[ST_W-1:0];
                ADDR_ROUTE: route_reg <= bus.pwdata[0];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers and filter
    // ----------------------------------------------------------------
    // 25 pins: nmi, eight lines, sixteen key inputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            syncA_reg <= '1;
            syncB_reg <= '1;
            syncC_reg <= '1;
        end else begin
            syncA_reg <= {nmiPin_n, irqPin_n, keyPin_n};
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
        end
    end

    // a change counts once the second and third stages agree
    assign agree = ~(syncB_reg ^ syncC_reg);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            filt_reg <= '1;
        end else begin
            filt_reg <= (syncB_reg & agree) | (filt_reg & ~agree);
        end
    end

    assign nmiLvl = filt_reg[24];
    assign irqLvl = filt_reg[23:16];
    assign keyLvl = filt_reg[15:0];

    // ----------------------------------------------------------------
    // external line sensing
    // ----------------------------------------------------------------
    // line 6 also fires on any unmasked key input
    assign keyHit = ~keyLvl & ~{keyHi_reg, keyLo_reg};

    always_comb begin
        lineLow = ~irqLvl;
        lineLow[KEY_LINE] = ~irqLvl[KEY_LINE] | (|keyHit);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lineLowPrev_reg <= '0;
            nmiPrev_reg <= 1'b1;
        end else begin
            lineLowPrev_reg <= lineLow;
            nmiPrev_reg <= nmiLvl;
        end
    end

    assign lineFall = lineLow & ~lineLowPrev_reg;

    // edge latch: set only while enabled, kept when enable later drops
    always_comb begin
        edgeClr = {NUM_EXT{ccrMask}} & ~sense_reg & ~enable_reg;
        if (ackHit && grant_reg.number >= VEC_EXT0
                && grant_reg.number < VEC_INT0) begin
            edgeClr[3'(grant_reg.number - VEC_EXT0)] = 1'b1;
        end
    end

    // a new edge wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            edgePend_reg <= '0;
        end else begin
            edgePend_reg <= (edgePend_reg & ~edgeClr)
                | (lineFall & enable_reg & sense_reg);
        end
    end

    // sense 1: latched falling edge, sense 0: live low level
    assign extReq = (sense_reg & edgePend_reg)
        | (~sense_reg & lineLow & enable_reg);

    // ----------------------------------------------------------------
    // nonmaskable and watchdog requests
    // ----------------------------------------------------------------
    assign nmiEdge = sysctl_reg[NMI_EDGE_BIT]
        ? (nmiLvl & ~nmiPrev_reg)
        : (~nmiLvl & nmiPrev_reg);
    assign nmiSet = nmiEdge | (wdtOvf & route_reg);
    assign wdtSet = wdtOvf & ~route_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nmiPend_reg <= 1'b0;
            wdtPend_reg <= 1'b0;
        end else begin
            nmiPend_reg <= nmiSet
                | (nmiPend_reg & ~(ackHit && grant_reg.number == VEC_NMI));
            wdtPend_reg <= wdtSet
                | (wdtPend_reg & ~(ackHit && grant_reg.number == VEC_WDT));
        end
    end

    always_comb begin
        intReq = internalReq;
        intReq[WDT_IDX] = internalReq[WDT_IDX] | wdtPend_reg;
    end

    // ----------------------------------------------------------------
    // priority resolution
    // ----------------------------------------------------------------
    // bit 0 is the nonmaskable request and is never gated
    assign reqs = {intReq & {NUM_INT{~ccrMask}},
        extReq & {NUM_EXT{~ccrMask}},
        nmiPend_reg};
    assign winIdx = firstSet(reqs);
    // numbers start above the reset and reserved entries
    assign winNum = winIdx + VEC_NMI;

    assign ackHit = (state_reg == ARB_OFFER) & intAck;

    always_comb begin
        state_next = state_reg;
        grant_next = grant_reg;
        unique case (state_reg)
            ARB_IDLE: begin
                if (|reqs) begin
                    grant_next.valid = 1'b1;
                    grant_next.number = winNum;
                    grant_next.addr = vecAddr(winNum);
                    state_next = ARB_OFFER;
                end
            end
            ARB_OFFER: begin
                // held unchanged until the core takes it
                if (intAck) begin
                    grant_next.valid = 1'b0;
                    state_next = ARB_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ARB_IDLE;
            grant_reg <= '{1'b0, 6'h00, RESET_VEC_ADDR};
        end else begin
            state_reg <= state_next;
            grant_reg <= grant_next;
        end
    end

    // ----------------------------------------------------------------
    // event status and interrupt output
    // ----------------------------------------------------------------
    always_comb begin
        events = '0;
        events[ST_NMI] = nmiSet;
        events[ST_GRANT] = ackHit;
        events[ST_KEY] = lineFall[KEY_LINE];
    end

    // write one clears; a new event in the same cycle wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_reg <= STATUS_RST;
        end else if (wrEn && bus.paddr == ADDR_STATUS) begin
            status_reg <= (status_reg & ~bus.pwdata[ST_W-1:0]) | events;
        end else begin
            status_reg <= status_reg | events;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqOut_reg <= 1'b0;
        end else begin
            irqOut_reg <= |(status_reg & mask_reg);
        end
    end

endmodule : prioritized_vectored_interrupt_ctrl

//--- prioritized_vectored_interrupt_ctrl_test.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps

`define CHECK(got, exp, msg) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("MISMATCH at %0t: %s got %h want %h", $time, msg, got, exp); \
        end \
    end

module prioritized_vectored_interrupt_ctrl_test;
    import intc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic nmiPin_n = 1'b1;
    logic [7:0] irqPin_n = 8'hff;
    logic [15:0] keyPin_n = 16'hffff;
    logic [25:0] internalReq = 26'h0;
    logic wdtOvf = 1'b0;
    logic ccrMask;
    logic intAck;
    grant_t grant;
    logic irqOut;
    logic [3:0] ackDelay = 4'h0;
    logic setI = 1'b0;
    logic clrI = 1'b0;
    logic [5:0] lastNumber;
    logic [7:0] ackCount;
    int fails = 0;
    int checks_done = 0;

    always #10 sys_clk = ~sys_clk;

    prioritized_vectored_interrupt_ctrl prioritized_vectored_interrupt_ctrl_i (
        .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .nmiPin_n, .irqPin_n, .keyPin_n, .internalReq, .wdtOvf, .ccrMask,
        .intAck, .grant, .irqOut);

    core_model core_model_i (
        .sys_clk, .rst, .grant, .intAck, .ccrMask, .ackDelay, .setI, .clrI, .lastNumber,
        .ackCount);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        `CHECK(n < 16, 1'b1, "bus answer")
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, {24'h0, d}, r, e);
    endtask : wr

    task automatic unmask();
        clrI <= 1'b1;
        @(posedge sys_clk);
        clrI <= 1'b0;
    endtask : unmask

    task automatic wait_grant(input logic [5:0] exp);
        logic [7:0] c0;
        int n;
        c0 = ackCount;
        n = 0;
        while (ackCount === c0 && n < 60) begin
            @(posedge sys_clk);
            n++;
        end
        `CHECK(ackCount !== c0, 1'b1, "no grant")
        `CHECK(lastNumber, exp, "vector")
    endtask : wait_grant

    task automatic no_grant();
        logic [7:0] c0;
        c0 = ackCount;
        repeat (24) @(posedge sys_clk);
        `CHECK(ackCount, c0, "extra grant")
    endtask : no_grant

    task automatic pulse_line2();
        irqPin_n[2] <= 1'b0;
        repeat (6) @(posedge sys_clk);
        irqPin_n[2] <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask : pulse_line2

    task automatic pulse_wdt();
        wdtOvf <= 1'b1;
        @(posedge sys_clk);
        wdtOvf <= 1'b0;
    endtask : pulse_wdt

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_registers();
        logic [ADDR_W-1:0] a [8] = '{ADDR_SYSCTL, ADDR_SENSE, ADDR_ENABLE, ADDR_KEYLO,
            ADDR_KEYHI, ADDR_STATUS, ADDR_MASK, ADDR_ROUTE};
        logic [7:0] v [8] = '{8'h09, 8'h00, 8'h00, 8'hbf, 8'hff, 8'h00, 8'h00, 8'h00};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 8; i++) begin
            apb(a[i], 1'b0, 32'h0, r, e);
            `CHECK(r, {24'h0, v[i]}, "reset value")
        end
        wr(ADDR_SYSCTL, 8'h00);
        apb(ADDR_SYSCTL, 1'b0, 32'h0, r, e);
        `CHECK(r, 32'h08, "read-only bit")
        wr(ADDR_SYSCTL, 8'h09);
        apb(18'h00000, 1'b0, 32'h0, r, e);
        `CHECK({e, r}, 33'h100000000, "unmapped read")
    endtask : test_registers

    task automatic test_nmi();
        nmiPin_n <= 1'b0;
        wait_grant(6'd3);
        wr(ADDR_SYSCTL, 8'h0d);
        nmiPin_n <= 1'b1;
        wait_grant(6'd3);
        nmiPin_n <= 1'b0;
        no_grant();
        wr(ADDR_SYSCTL, 8'h09);
    endtask : test_nmi

    task automatic test_sources();
        wr(ADDR_ENABLE, 8'hff);
        for (int n = 0; n < 8; n++) begin
            irqPin_n[n] <= 1'b0;
            unmask();
            wait_grant(6'd4 + 6'(n));
            irqPin_n[n] <= 1'b1;
            repeat (8) @(posedge sys_clk);
        end
        wr(ADDR_ENABLE, 8'h00);
        ackDelay <= 4'h5;
        for (int i = 0; i < 26; i++) begin
            internalReq <= 26'h1 << i;
            unmask();
            wait_grant(6'd12 + 6'(i));
            internalReq <= 26'h0;
            repeat (2) @(posedge sys_clk);
        end
        ackDelay <= 4'h0;
    endtask : test_sources

    task automatic test_priority();
        irqPin_n[0] <= 1'b0;
        internalReq <= 26'h2000001;
        wr(ADDR_ENABLE, 8'h01);
        no_grant();
        unmask();
        wait_grant(6'd4);
        irqPin_n[0] <= 1'b1;
        repeat (8) @(posedge sys_clk);
        unmask();
        wait_grant(6'd12);
        internalReq <= 26'h2000000;
        unmask();
        wait_grant(6'd37);
        internalReq <= 26'h0;
        wr(ADDR_ENABLE, 8'h00);
    endtask : test_priority

    task automatic test_edge_pending();
        wr(ADDR_SENSE, 8'h04);
        wr(ADDR_ENABLE, 8'h04);
        pulse_line2();
        wr(ADDR_ENABLE, 8'h00);
        unmask();
        wait_grant(6'd6);
        wr(ADDR_ENABLE, 8'h04);
        pulse_line2();
        wr(ADDR_ENABLE, 8'h00);
        wr(ADDR_SENSE, 8'h00);
        wr(ADDR_SENSE, 8'h04);
        unmask();
        no_grant();
        setI <= 1'b1;
        @(posedge sys_clk);
        setI <= 1'b0;
        wr(ADDR_SENSE, 8'h00);
    endtask : test_edge_pending

    task automatic test_keys();
        wr(ADDR_ENABLE, 8'h40);
        keyPin_n <= 16'h7ffe;
        unmask();
        no_grant();
        wr(ADDR_KEYLO, 8'hbe);
        wait_grant(6'd10);
        wr(ADDR_KEYLO, 8'hbf);
        wr(ADDR_KEYHI, 8'h7f);
        unmask();
        wait_grant(6'd10);
        keyPin_n <= 16'hffff;
        repeat (8) @(posedge sys_clk);
        wr(ADDR_KEYHI, 8'hff);
        wr(ADDR_ENABLE, 8'h00);
    endtask : test_keys

    task automatic test_watchdog();
        wr(ADDR_ROUTE, 8'h01);
        pulse_wdt();
        wait_grant(6'd3);
        wr(ADDR_ROUTE, 8'h00);
        pulse_wdt();
        no_grant();
        unmask();
        wait_grant(6'd36);
    endtask : test_watchdog

    task automatic test_event_irq();
        logic [31:0] r;
        logic e;
        `CHECK(irqOut, 1'b0, "irq masked")
        wr(ADDR_MASK, 8'h01);
        repeat (2) @(posedge sys_clk);
        `CHECK(irqOut, 1'b1, "irq set")
        wr(ADDR_STATUS, 8'h01);
        repeat (2) @(posedge sys_clk);
        `CHECK(irqOut, 1'b0, "irq clear")
        apb(ADDR_STATUS, 1'b0, 32'h0, r, e);
        `CHECK(r[0], 1'b0, "status clear")
        wr(ADDR_MASK, 8'h00);
    endtask : test_event_irq

    // ------------------------------------------------------------
    // sequence and verdict
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        test_registers();
        test_nmi();
        test_sources();
        test_priority();
        test_edge_pending();
        test_keys();
        test_watchdog();
        test_event_irq();
        finish_test();
    end

    initial begin
        #400000;
        fails++;
        finish_test();
    end
endmodule : prioritized_vectored_interrupt_ctrl_test
